//--- pic_pkg.sv
// constants shared by the interrupt controller and its priority resolver
//
// Notes on behaviour
// - sixty-four input channels, sixteen of them fed by external sources
// - each channel has its own enable; a disabled channel never requests the core
// - two request outputs to the core: fast and normal
// - each channel is steered to fast or normal individually by software
// - each channel carries one of eight programmable priority levels
// - levels 0 and 1 are fast requests, levels 2 to 7 are normal requests
// - among equal levels the lowest channel number wins
// - on an interrupt the entry register shows the winner's service routine address
// - software programs a per-channel entry address table and per-channel levels
// - fixed channel map: video low, timers from 32, general io from 44, emulation 63
`default_nettype none

package pic_pkg;

	// ----------------------------------------------------------------
	// channel layout
	// ----------------------------------------------------------------
	localparam int NUM_CH = 64;
	localparam int EXT_CH = 16;
	localparam int CH_W = 6;
	localparam int LVL_W = 3;
	localparam int NUM_LEVELS = 8;
	localparam int FAST_LEVELS = 2;
	localparam logic [LVL_W-1:0] FAST_LVL_LIMIT = 3'h2;
	localparam int VIDEO_BASE = 0;
	localparam int TIMER_BASE = 32;
	localparam int GPIO_BASE = 44;
	localparam int EMU_CH = 63;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] PEND_LO_OFS = 12'h000;
	localparam logic [11:0] PEND_HI_OFS = 12'h004;
	localparam logic [11:0] MASK_LO_OFS = 12'h008;
	localparam logic [11:0] MASK_HI_OFS = 12'h00C;
	localparam logic [11:0] FAST_ENTRY_OFS = 12'h010;
	localparam logic [11:0] NORMAL_ENTRY_OFS = 12'h014;
	localparam logic [11:0] WINNER_OFS = 12'h018;
	localparam logic [11:0] RAW_LO_OFS = 12'h01C;
	localparam logic [11:0] RAW_HI_OFS = 12'h020;
	localparam logic [11:0] PRIO_BASE_OFS = 12'h040;
	localparam logic [11:0] PRIO_END_OFS = 12'h05C;
	localparam logic [11:0] TABLE_BASE_OFS = 12'h100;
	localparam logic [11:0] TABLE_END_OFS = 12'h1FC;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int PRIO_FIELD_W = 4;
	localparam int PRIO_PER_REG = 8;
	localparam int WIN_FAST_CH_LSB = 0;
	localparam int WIN_FAST_VALID_BIT = 8;
	localparam int WIN_NORMAL_CH_LSB = 16;
	localparam int WIN_NORMAL_VALID_BIT = 24;
	localparam logic [LVL_W-1:0] PRIO_RST = 3'h7;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	localparam logic [31:0] ENTRY_RST = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

//--- resolve_if.sv
// carrier between the register side and the priority resolver
`default_nettype none

interface resolve_if;
	import pic_pkg::*;
	logic [NUM_CH-1:0] req;
	logic [NUM_CH-1:0][LVL_W-1:0] lvl;
	logic fast_valid;
	logic [CH_W-1:0] fast_ch;
	logic normal_valid;
	logic [CH_W-1:0] normal_ch;

	modport ctrl (
		output req,
		output lvl,
		input fast_valid,
		input fast_ch,
		input normal_valid,
		input normal_ch
	);
	modport resolver (
		input req,
		input lvl,
		output fast_valid,
		output fast_ch,
		output normal_valid,
		output normal_ch
	);
endinterface

`default_nettype wire

//--- priority_resolver.sv
// combinational winner search for the fast and the normal request groups
`default_nettype none

module priority_resolver
	import pic_pkg::*;
(
	resolve_if.resolver rif
);

	typedef struct packed {
		logic valid;
		logic [CH_W-1:0] ch;
	} pick_t;

	// scanning downward with <= lets the lower channel win a tie
	function automatic pick_t pick(
		input logic [NUM_CH-1:0] req,
		input logic [NUM_CH-1:0][LVL_W-1:0] lvl,
		input logic want_fast
	);
		pick_t best;
		logic [LVL_W-1:0] best_lvl;
		logic is_fast;
		best = '0;
		best_lvl = '1;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			is_fast = (lvl[i] < FAST_LVL_LIMIT);
			if (req[i] && (is_fast == want_fast) && (!best.valid || lvl[i] <= best_lvl)) begin
				best.valid = 1'b1;
				best.ch = CH_W'(i);
				best_lvl = lvl[i];
			end
		end
		return best;
	endfunction

	pick_t fast_pick;
	pick_t normal_pick;

	always_comb begin
		fast_pick = pick(rif.req, rif.lvl, 1'b1);
		normal_pick = pick(rif.req, rif.lvl, 1'b0);
	end

	assign rif.fast_valid = fast_pick.valid;
	assign rif.fast_ch = fast_pick.ch;
	assign rif.normal_valid = normal_pick.valid;
	assign rif.normal_ch = normal_pick.ch;

endmodule

`default_nettype wire

//--- priority_interrupt_controller.sv
// interrupt controller top: source capture, masking, arbitration, entry table, AXI4-Lite slave
//
// Local design decisions: the address map and the AXI4-Lite register port.
`default_nettype none

module priority_interrupt_controller
	import pic_pkg::*;
#(
	parameter int N_CH = NUM_CH
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [N_CH-1:0] irq_src,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic fast_interrupt_request,
	output logic normal_interrupt_request
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_strb(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_val[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic in_range(
		input logic [ADDR_W-1:0] a,
		input logic [11:0] lo,
		input logic [11:0] hi
	);
		return (a >= lo) && (a <= hi);
	endfunction

	// ----------------------------------------------------------------
	// source capture
	// ----------------------------------------------------------------
	// every channel n is wired from source n; shared channels are chosen
	// upstream by the shared source select register
	logic [N_CH-1:0] src_meta_reg;
	logic [N_CH-1:0] src_sync_reg;
	logic [N_CH-1:0] src_last_reg;
	logic [N_CH-1:0] src_rise;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			src_meta_reg <= '0;
			src_sync_reg <= '0;
			src_last_reg <= '0;
		end else begin
			src_meta_reg <= irq_src;
			src_sync_reg <= src_meta_reg;
			src_last_reg <= src_sync_reg;
		end
	end

	assign src_rise = src_sync_reg & ~src_last_reg;

	// ----------------------------------------------------------------
	// configuration state
	// ----------------------------------------------------------------
	logic [N_CH-1:0] pend_reg;
	logic [N_CH-1:0] pend_next;
	logic [N_CH-1:0] mask_reg;
	logic [N_CH-1:0][LVL_W-1:0] prio_reg;
	logic [31:0] entry_table [N_CH];
	logic [31:0] fast_entry_reg;
	logic [31:0] normal_entry_reg;
	logic [CH_W-1:0] fast_ch_reg;
	logic [CH_W-1:0] normal_ch_reg;
	logic fast_valid_reg;
	logic normal_valid_reg;

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic wr_ok;
	logic [CH_W-1:0] wr_tbl_idx;
	logic [2:0] wr_prio_idx;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_tbl_idx = aw_addr_reg[CH_W+1:2];
	assign wr_prio_idx = aw_addr_reg[4:2];
	assign wr_ok = (aw_addr_reg[1:0] == 2'h0) &&
		((aw_addr_reg == PEND_LO_OFS) || (aw_addr_reg == PEND_HI_OFS) ||
		(aw_addr_reg == MASK_LO_OFS) || (aw_addr_reg == MASK_HI_OFS) ||
		in_range(aw_addr_reg, PRIO_BASE_OFS, PRIO_END_OFS) ||
		in_range(aw_addr_reg, TABLE_BASE_OFS, TABLE_END_OFS));

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// enables, one bit per channel
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mask_reg <= {2{MASK_RST}};
		end else if (wr_fire && aw_addr_reg == MASK_LO_OFS) begin
			mask_reg[31:0] <= merge_strb(mask_reg[31:0], w_data_reg, w_strb_reg);
		end else if (wr_fire && aw_addr_reg == MASK_HI_OFS) begin
			mask_reg[63:32] <= merge_strb(mask_reg[63:32], w_data_reg, w_strb_reg);
		end
	end

	// levels, eight channels to a word, four bits per field
	always_ff @(posedge sys_clk) begin
		logic [31:0] packed_word;
		logic [31:0] merged;
		packed_word = '0;
		merged = '0;
		if (sys_rst) begin
			prio_reg <= {N_CH{PRIO_RST}};
		end else if (wr_fire && aw_addr_reg[1:0] == 2'h0 &&
			in_range(aw_addr_reg, PRIO_BASE_OFS, PRIO_END_OFS)) begin
			for (int k = 0; k < PRIO_PER_REG; k++) begin
				packed_word[PRIO_FIELD_W*k +: LVL_W] = prio_reg[wr_prio_idx*PRIO_PER_REG + k];
			end
			merged = merge_strb(packed_word, w_data_reg, w_strb_reg);
			for (int k = 0; k < PRIO_PER_REG; k++) begin
				prio_reg[wr_prio_idx*PRIO_PER_REG + k] <= merged[PRIO_FIELD_W*k +: LVL_W];
			end
		end
	end

	// entry address table; kept out of reset so it can map onto a ram
	always_ff @(posedge sys_clk) begin
		// a misaligned write is refused and must leave the table untouched
		if (wr_fire && aw_addr_reg[1:0] == 2'h0 &&
			in_range(aw_addr_reg, TABLE_BASE_OFS, TABLE_END_OFS)) begin
			entry_table[wr_tbl_idx] <=
				merge_strb(entry_table[wr_tbl_idx], w_data_reg, w_strb_reg);
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	logic rd_fire;
	logic [31:0] rd_word;
	logic rd_ok;
	logic [CH_W-1:0] rd_tbl_idx;
	logic [2:0] rd_prio_idx;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_tbl_idx = s_axi_araddr[CH_W+1:2];
	assign rd_prio_idx = s_axi_araddr[4:2];

	always_comb begin
		rd_word = '0;
		rd_ok = (s_axi_araddr[1:0] == 2'h0);
		if (in_range(s_axi_araddr, PRIO_BASE_OFS, PRIO_END_OFS)) begin
			for (int k = 0; k < PRIO_PER_REG; k++) begin
				rd_word[PRIO_FIELD_W*k +: LVL_W] = prio_reg[rd_prio_idx*PRIO_PER_REG + k];
			end
		end else if (in_range(s_axi_araddr, TABLE_BASE_OFS, TABLE_END_OFS)) begin
			rd_word = entry_table[rd_tbl_idx];
		end else begin
			case (s_axi_araddr)
				PEND_LO_OFS: rd_word = pend_reg[31:0];
				PEND_HI_OFS: rd_word = pend_reg[63:32];
				MASK_LO_OFS: rd_word = mask_reg[31:0];
				MASK_HI_OFS: rd_word = mask_reg[63:32];
				FAST_ENTRY_OFS: rd_word = fast_entry_reg;
				NORMAL_ENTRY_OFS: rd_word = normal_entry_reg;
				WINNER_OFS: begin
					rd_word[WIN_FAST_CH_LSB +: CH_W] = fast_ch_reg;
					rd_word[WIN_FAST_VALID_BIT] = fast_valid_reg;
					rd_word[WIN_NORMAL_CH_LSB +: CH_W] = normal_ch_reg;
					rd_word[WIN_NORMAL_VALID_BIT] = normal_valid_reg;
				end
				RAW_LO_OFS: rd_word = src_sync_reg[31:0];
				RAW_HI_OFS: rd_word = src_sync_reg[63:32];
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// pending flags
	// ----------------------------------------------------------------
	// a read of a pending word clears the bits it returned; an edge in the
	// same cycle survives because the set is applied after the clear
	always_comb begin
		pend_next = pend_reg;
		if (rd_fire && s_axi_araddr == PEND_LO_OFS) begin
			pend_next[31:0] = '0;
		end
		if (rd_fire && s_axi_araddr == PEND_HI_OFS) begin
			pend_next[63:32] = '0;
		end
		pend_next = pend_next | src_rise;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= pend_next;
		end
	end

	// ----------------------------------------------------------------
	// arbitration
	// ----------------------------------------------------------------
	resolve_if rif ();

	assign rif.req = pend_reg & mask_reg;
	assign rif.lvl = prio_reg;

	priority_resolver u_resolver (
		.rif(rif)
	);

	// entries are registered so a read never sees a half-settled search
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fast_valid_reg <= 1'b0;
			fast_ch_reg <= '0;
			fast_entry_reg <= ENTRY_RST;
		end else begin
			fast_valid_reg <= rif.fast_valid;
			fast_ch_reg <= rif.fast_ch;
			fast_entry_reg <= rif.fast_valid ? entry_table[rif.fast_ch] : ENTRY_RST;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			normal_valid_reg <= 1'b0;
			normal_ch_reg <= '0;
			normal_entry_reg <= ENTRY_RST;
		end else begin
			normal_valid_reg <= rif.normal_valid;
			normal_ch_reg <= rif.normal_ch;
			normal_entry_reg <= rif.normal_valid ? entry_table[rif.normal_ch] : ENTRY_RST;
		end
	end

	// ----------------------------------------------------------------
	// requests to the core
	// ----------------------------------------------------------------
	// driven from the same registers as the entries, so the core never
	// sees a request before its entry address is ready
	assign fast_interrupt_request = fast_valid_reg;
	assign normal_interrupt_request = normal_valid_reg;

endmodule

`default_nettype wire

//--- priority_interrupt_controller_properties.sv
// port assertions for the interrupt controller
`default_nettype none

module priority_interrupt_controller_properties
	import pic_pkg::*;
#(
	parameter int N_CH = NUM_CH
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [N_CH-1:0] irq_src,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fast_interrupt_request,
	input wire logic normal_interrupt_request
);
	// masks reset to disabled, so until the first write no request may appear
	logic written_reg;

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			written_reg <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			written_reg <= 1'b1;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_idle_quiet: assert property (
		!written_reg |-> !fast_interrupt_request && !normal_interrupt_request)
		else $error("request with all channels disabled");
	a_reset_state: assert property (
		$past(sys_rst) |-> !fast_interrupt_request && !normal_interrupt_request && !s_axi_bvalid)
		else $error("outputs not idle after reset");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_rdata_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_write_refuse: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_refuse: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_err_zero: assert property (
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read with nonzero data");
endmodule

bind priority_interrupt_controller priority_interrupt_controller_properties #(.N_CH(N_CH)) props (.*);

`default_nettype wire

//--- irq_source_model.sv
// model of the peripheral side: drives the channel lines for a chosen time
`default_nettype none

module irq_source_model
	import pic_pkg::*;
(
	input wire logic sys_clk,
	output logic [NUM_CH-1:0] irq_src
);
	timeunit 1ns;
	timeprecision 1ns;

	initial irq_src = '0;

	// shared channels arrive already resolved to one source each
	task automatic fire(input logic [NUM_CH-1:0] lines, input int hold);
		irq_src <= irq_src | lines;
		repeat (hold) @(posedge sys_clk);
		irq_src <= irq_src & ~lines;
	endtask
endmodule

`default_nettype wire

//--- test_priority_interrupt_controller.sv
// bench for the interrupt controller: register map, masking, arbitration, entries
`default_nettype none

module test_priority_interrupt_controller
	import pic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [NUM_CH-1:0] irq_src;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic fast_interrupt_request, normal_interrupt_request;
	logic [2:0] lvl [NUM_CH];
	logic [31:0] ent [NUM_CH];
	logic [63:0] m, msk;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;

	irq_source_model src (.sys_clk(sys_clk), .irq_src(irq_src));
	priority_interrupt_controller #(.N_CH(NUM_CH)) uut (.*);

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	// a full run needs about 3000 cycles
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// bready may start low, but once raised it stays up until the response
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			done = s_axi_bvalid && s_axi_bready;
			s_axi_bready <= !done && (s_axi_bready || $urandom_range(3) == 0);
		end while (!done);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] er = RESP_OKAY, input logic [31:0] sel = 32'hFFFF_FFFF);
		logic done;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			done = s_axi_rvalid && s_axi_rready;
			s_axi_rready <= !done && (s_axi_rready || $urandom_range(3) == 0);
		end while (!done);
		chk(what, exp & sel, s_axi_rdata & sel);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	function automatic logic [6:0] pick(input logic [63:0] p, input logic want_fast);
		logic [6:0] r;
		r = 7'h0;
		for (int i = 0; i < NUM_CH; i++)
			if (p[i] && (lvl[i] < FAST_LVL_LIMIT) == want_fast)
				if (!r[6] || lvl[i] < lvl[r[5:0]])
					r = {1'b1, 6'(i)};
		return r;
	endfunction

	function automatic logic [31:0] wfmt(input logic [6:0] f, input logic [6:0] n);
		return {7'h0, n[6], 2'h0, n[5:0], 7'h0, f[6], 2'h0, f[5:0]};
	endfunction

	task automatic check_state(input logic [63:0] p);
		logic [6:0] f, n;
		f = pick(p, 1'b1);
		n = pick(p, 1'b0);
		chk("fast_req", {31'h0, f[6]}, {31'h0, fast_interrupt_request});
		chk("normal_req", {31'h0, n[6]}, {31'h0, normal_interrupt_request});
		rdc("fast_entry", FAST_ENTRY_OFS, f[6] ? ent[f[5:0]] : 32'h0);
		rdc("normal_entry", NORMAL_ENTRY_OFS, n[6] ? ent[n[5:0]] : 32'h0);
		rdc("winner", WINNER_OFS, wfmt(f, n), RESP_OKAY,
			wfmt({1'b1, {6{f[6]}}}, {1'b1, {6{n[6]}}}));
	endtask

	task automatic clear(input logic [63:0] p);
		rdc("pend_lo", PEND_LO_OFS, p[31:0]);
		rdc("pend_hi", PEND_HI_OFS, p[63:32]);
		repeat (3) @(posedge sys_clk);
		check_state(64'h0);
	endtask

	task automatic set_levels();
		logic [31:0] d;
		for (int i = 0; i < NUM_CH; i++) begin
			lvl[i] = 3'($urandom_range(7));
			d[4 * (i % 8) +: 4] = {1'b0, lvl[i]};
			if (i % 8 == 7) wr(PRIO_BASE_OFS + 12'(4 * (i / 8)), d, RESP_OKAY);
		end
	endtask

	initial begin
		void'($urandom(32'hFB07));
		for (int i = 0; i < NUM_CH; i++)
			lvl[i] = 3'h7;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rdc("mask_lo", MASK_LO_OFS, MASK_RST);
		rdc("prio_word", PRIO_BASE_OFS + 12'h4, 32'h7777_7777);
		rdc("unmapped", 12'h300, 32'h0, RESP_SLVERR);
		wr(FAST_ENTRY_OFS, 32'h1, RESP_SLVERR);
		for (int i = 0; i < NUM_CH; i++) begin
			ent[i] = $urandom;
			wr(TABLE_BASE_OFS + 12'(4 * i), ent[i], RESP_OKAY);
		end
		wr(TABLE_BASE_OFS + 12'h2, 32'h1, RESP_SLVERR);
		rdc("entry0", TABLE_BASE_OFS, ent[0]);
		$display("test register_map done");
		msk = 64'h0;
		m = 64'h8000_1001_0000_0001;
		src.fire(m, 2);
		repeat (4) @(posedge sys_clk);
		check_state(m & msk);
		msk = '1;
		wr(MASK_LO_OFS, 32'hFFFF_FFFF, RESP_OKAY);
		wr(MASK_HI_OFS, 32'hFFFF_FFFF, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		check_state(m & msk);
		clear(m);
		$display("test mask_and_tie done");
		for (int t = 0; t < 24; t++) begin
			set_levels();
			msk = {$urandom, $urandom};
			m = (t == 0) ? '1 : {$urandom & $urandom, $urandom & $urandom};
			wr(MASK_LO_OFS, msk[31:0], RESP_OKAY);
			wr(MASK_HI_OFS, msk[63:32], RESP_OKAY);
			src.fire(m, $urandom_range(1, 4));
			repeat (4) @(posedge sys_clk);
			check_state(m & msk);
			clear(m);
		end
		$display("test random_arbitration done");
		conclude();
	end
endmodule

`default_nettype wire
